/* rtl/usu_pkg.sv */
package usu_pkg;
  // System clock and link timing.
  localparam int CLK_NS = 100;
  localparam int LINK_HALF_NS = 400;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] HALF_LAST = 3'(LINK_HALF_CYC - 1);

  // Device register port addresses.
  localparam logic [1:0] DEV_DATA = 2'h0;
  localparam logic [1:0] DEV_STAT = 2'h1;
  localparam logic [1:0] DEV_CTRL = 2'h2;

  // Control register fields.
  localparam int CTL_SIE = 7;
  localparam int CTL_OIE = 6;
  localparam int CTL_WM_HI = 5;
  localparam int CTL_WM_LO = 4;
  localparam int CTL_CS1 = 3;
  localparam int CTL_CS0 = 2;
  localparam int CTL_CLK = 1;
  localparam int CTL_TC = 0;

  // Status register fields.
  localparam int ST_SIF = 7;
  localparam int ST_OIF = 6;
  localparam int ST_PIF = 5;
  localparam int ST_DC = 4;

  // Wire modes; any mode with the upper bit set is two-wire.
  localparam logic [1:0] WM_OFF = 2'h0;
  localparam logic [1:0] WM_THREE = 2'h1;
  localparam logic [1:0] WM_TWO = 2'h2;

  localparam logic [3:0] CNT_MAX = 4'hF;
  localparam logic [7:0] SHIFT_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic PORT_CLK_RST = 1'b1;
  localparam logic DOUT_RST = 1'b1;

  // Controller register map and fields.
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_TX = 4'h4;
  localparam logic [3:0] OFF_RX = 4'h8;
  localparam logic [3:0] OFF_STAT = 4'hC;
  localparam int HC_GO = 0;
  localparam int HC_TWO = 1;
  localparam int HC_START = 2;
  localparam int HC_STOP = 3;
  localparam int HC_NACK = 4;
  localparam int HC_READ = 5;
  localparam logic [4:0] HCTRL_RST = 5'h01;
  localparam int HS_BUSY = 0;
  localparam int HS_ACK = 1;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] ACK_IDX = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] sr;
    logic [3:0] cnt;
    logic sif;
    logic oif;
    logic pif;
    logic hold;
    logic [7:0] ctl;
    logic port_clk;
    logic dout;
    logic [7:0] rdata;
  } usu_dev_state_t;

  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_START = 5'h02,
    H_LOW = 5'h04,
    H_HIGH = 5'h08,
    H_STOP = 5'h10
  } usu_hstate_t;

  typedef struct packed {
    usu_hstate_t st;
    logic [2:0] tmr;
    logic [3:0] idx;
    logic ph;
    logic scl;
    logic sda;
    logic [7:0] tx;
    logic [7:0] rx;
    logic ack;
    logic [4:0] ctl;
    logic aw_got;
    logic [3:0] waddr;
    logic w_got;
    logic [7:0] wdat;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } usu_host_state_t;
endpackage

/* rtl/usu_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Open-drain lines are resolved here with a pull-up: a low enable drives.
interface usu_if;
  logic h_scl_o;
  logic h_scl_oen;
  logic h_sda_o;
  logic h_sda_oen;
  logic d_scl_o;
  logic d_scl_oen;
  logic d_sda_o;
  logic d_sda_oen;
  logic d_do_o;
  logic d_do_oen;
  logic scl;
  logic sda;
  logic dout;
  assign scl = (h_scl_oen | h_scl_o) & (d_scl_oen | d_scl_o);
  assign sda = (h_sda_oen | h_sda_o) & (d_sda_oen | d_sda_o);
  assign dout = d_do_oen | d_do_o;
  modport dev (output d_scl_o, d_scl_oen, d_sda_o, d_sda_oen, d_do_o,
    d_do_oen, input scl, sda);
  modport host (output h_scl_o, h_scl_oen, h_sda_o, h_sda_oen,
    input scl, sda, dout);
endinterface
`default_nettype wire

/* rtl/usu_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module usu_sync (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_pin,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);
  logic [2:0] s_ff;
  logic [2:0] nxt_s;
  always_comb begin
    nxt_s = {i_pin, s_ff[2:1]};
  end
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      s_ff <= 3'h7;
    end else begin
      s_ff <= nxt_s;
    end
  end
  // Bit 2 is the first stage and is read only by bit 1.
  assign o_level = s_ff[1];
  assign o_rise = s_ff[1] & ~s_ff[0];
  assign o_fall = ~s_ff[1] & s_ff[0];
endmodule
`default_nettype wire

/* rtl/usu_unit.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [R01] Two-wire bit level, no slew or filtering.
// [R02] Software picks falling-edge shifting in two-wire.
// [R03] Slave stretches; master waits for SCL high.
// [R04] Master starts by pulling SDA low, SCL high.
// [R05] Start detection sets the start flag.
// [R06] After start, first SCL fall held low.
// [R07] Slave shifts SDA in on SCL rise.
// [R08] Counter overflow forces SCL low.
// [R09] Software preloads counter 14 to acknowledge.
// [R10] Last byte unacknowledged ends the transfer.
// [R11] Start detector only active in two-wire.
// [R12] Serial clock at most quarter system clock.
// [R13] External clock counts both edges.
// [R14] Counter at max overflows on next edge.
// [R15] CPU write wins over same-cycle shift.
// [R16] Left shift from selected clock source.
// [R17] Inputs work even with outputs disabled.
// [R18] Data pin follows bit 7 through latch.
// [R19] Data pin driven only when direction set.
// [R20] Otherwise start flag sets on counter increment.
// [R21] Flag plus enables request interrupt; write-one clears.
// [R22] Overflow flag on wrap; clearing releases SCL.
// [R23] Mode 00 outputs off, 01 three-wire.
// [R24] Counter and shifter share the clock event except with the external clock.
module usu_unit
  import usu_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_resetn,
  usu_if.dev bus,
  input wire logic i_cpu_wr,
  input wire logic i_cpu_rd,
  input wire logic [1:0] i_cpu_addr,
  input wire logic [7:0] i_cpu_wdata,
  output logic [7:0] o_cpu_rdata,
  input wire logic i_timer_match,
  input wire logic i_global_ie,
  input wire logic i_data_dir,
  input wire logic i_clk_dir,
  input wire logic i_port_data,
  output logic o_start_irq,
  output logic o_ovf_irq
);
  usu_dev_state_t s_ff;
  usu_dev_state_t nxt_s;
  logic sc_level;
  logic sc_rise;
  logic sc_fall;
  logic sd_level;
  logic sd_rise;
  logic sd_fall;
  logic [1:0] wm;
  logic two;
  logic three;
  logic cs1;
  logic cs0;
  logic ctl_wr;
  logic stat_wr;
  logic dat_wr;
  logic sw_clk;
  logic tc;
  logic shift_evt;
  logic cnt_evt;
  logic ovf_set;
  logic start_det;
  logic latch_open;
  logic scl_hold;

  // Plain two-stage sampling, no glitch filter. [R01]
  usu_sync u_scl (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_pin(bus.scl),
    .o_level(sc_level),
    .o_rise(sc_rise),
    .o_fall(sc_fall)
  );

  usu_sync u_sda (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_pin(bus.sda),
    .o_level(sd_level),
    .o_rise(sd_rise),
    .o_fall(sd_fall)
  );

  always_comb begin
    wm = s_ff.ctl[CTL_WM_HI:CTL_WM_LO];
    two = wm[1];
    three = (wm == WM_THREE); // [R23]
    cs1 = s_ff.ctl[CTL_CS1];
    cs0 = s_ff.ctl[CTL_CS0];
    ctl_wr = i_cpu_wr & (i_cpu_addr == DEV_CTRL);
    stat_wr = i_cpu_wr & (i_cpu_addr == DEV_STAT);
    dat_wr = i_cpu_wr & (i_cpu_addr == DEV_DATA);
    sw_clk = ctl_wr & i_cpu_wdata[CTL_CLK] & ~i_cpu_wdata[CTL_CS1];
    tc = ctl_wr & i_cpu_wdata[CTL_TC];
    // Clock inputs are used whatever the wire mode. [R17]
    if (cs1) begin
      shift_evt = cs0 ? sc_fall : sc_rise; // [R16] [R07]
      cnt_evt = s_ff.ctl[CTL_CLK] ? tc : (sc_rise | sc_fall); // [R13]
    end else begin
      shift_evt = cs0 ? i_timer_match : sw_clk; // [R16]
      cnt_evt = shift_evt; // [R24]
    end
    ovf_set = cnt_evt & (s_ff.cnt == CNT_MAX); // [R14] [R22]
    start_det = two & sc_level & sd_fall; // [R11]
    latch_open = ~cs1 | (sc_level == cs0);
  end

  always_comb begin
    nxt_s = s_ff;
    // A CPU write keeps its value over a same-cycle shift. [R15]
    if (dat_wr) begin
      nxt_s.sr = i_cpu_wdata;
    end else if (shift_evt) begin
      nxt_s.sr = {s_ff.sr[6:0], sd_level}; // [R16] [R17]
    end
    // Software may preload the counter, e.g. to 14 for an ack. [R09]
    if (stat_wr) begin
      nxt_s.cnt = i_cpu_wdata[3:0];
    end else if (cnt_evt) begin
      nxt_s.cnt = s_ff.cnt + 4'h1; // [R24]
    end
    // Flags clear on a written one; a same-cycle set wins. [R21]
    nxt_s.sif = (two ? start_det : cnt_evt) // [R05] [R20]
      | (s_ff.sif & ~(stat_wr & i_cpu_wdata[ST_SIF]));
    nxt_s.oif = ovf_set
      | (s_ff.oif & ~(stat_wr & i_cpu_wdata[ST_OIF])); // [R22]
    nxt_s.pif = (two & sc_level & sd_rise)
      | (s_ff.pif & ~(stat_wr & i_cpu_wdata[ST_PIF]));
    // Hold armed by the first SCL fall after a start. [R06]
    nxt_s.hold = two & nxt_s.sif & (s_ff.hold | (s_ff.sif & sc_fall));
    if (ctl_wr) begin
      nxt_s.ctl = {i_cpu_wdata[7:1], 1'b0};
    end
    if (tc) begin
      nxt_s.port_clk = ~s_ff.port_clk;
    end
    if (latch_open) begin
      nxt_s.dout = nxt_s.sr[7]; // [R18]
    end
    if (i_cpu_rd) begin
      case (i_cpu_addr)
        DEV_DATA: nxt_s.rdata = s_ff.sr;
        DEV_STAT: nxt_s.rdata = {s_ff.sif, s_ff.oif, s_ff.pif,
          two & (s_ff.sr[7] != sd_level), s_ff.cnt};
        DEV_CTRL: nxt_s.rdata = s_ff.ctl;
        default: nxt_s.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      s_ff.sr <= SHIFT_RST;
      s_ff.cnt <= CNT_RST;
      s_ff.sif <= 1'b0;
      s_ff.oif <= 1'b0;
      s_ff.pif <= 1'b0;
      s_ff.hold <= 1'b0;
      s_ff.ctl <= CTRL_RST;
      s_ff.port_clk <= PORT_CLK_RST;
      s_ff.dout <= DOUT_RST;
      s_ff.rdata <= 8'h00;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Clearing both the start flag and the overflow flag releases this hold. [R08] [R22]
  assign scl_hold = two & (s_ff.hold | s_ff.oif); // [R06]

  always_comb begin
    bus.d_scl_o = 1'b1;
    bus.d_scl_oen = 1'b1;
    bus.d_sda_o = 1'b1;
    bus.d_sda_oen = 1'b1;
    bus.d_do_o = 1'b1;
    bus.d_do_oen = 1'b1;
    if (two) begin
      bus.d_scl_o = 1'b0;
      bus.d_scl_oen = ~(scl_hold | (i_clk_dir & ~s_ff.port_clk));
      bus.d_sda_o = 1'b0;
      bus.d_sda_oen = ~(i_data_dir & ~(s_ff.dout & i_port_data)); // [R19]
    end else if (three) begin
      bus.d_scl_o = s_ff.port_clk;
      bus.d_scl_oen = ~i_clk_dir;
      bus.d_do_o = s_ff.dout;
      bus.d_do_oen = ~i_data_dir; // [R19]
    end
  end

  assign o_cpu_rdata = s_ff.rdata;
  assign o_start_irq = s_ff.sif & s_ff.ctl[CTL_SIE] & i_global_ie; // [R21]
  assign o_ovf_irq = s_ff.oif & s_ff.ctl[CTL_OIE] & i_global_ie; // [R14]
endmodule
`default_nettype wire

/* rtl/usu_master.sv */
`timescale 1ns/1ps
`default_nettype none
module usu_master
  import usu_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_resetn,
  usu_if.host bus,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [3:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [3:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp
);
  usu_host_state_t s_ff;
  usu_host_state_t nxt_s;
  logic scl_lvl;
  logic sda_lvl;
  logic do_lvl;
  logic two;
  logic din;
  logic last;
  logic wfire;
  logic idle;
  logic map_ok;

  usu_sync u_scl (.i_clock(i_clock), .i_resetn(i_resetn), .i_pin(bus.scl),
    .o_level(scl_lvl), .o_rise(), .o_fall());
  usu_sync u_sda (.i_clock(i_clock), .i_resetn(i_resetn), .i_pin(bus.sda),
    .o_level(sda_lvl), .o_rise(), .o_fall());
  usu_sync u_do (.i_clock(i_clock), .i_resetn(i_resetn), .i_pin(bus.dout),
    .o_level(do_lvl), .o_rise(), .o_fall());

  always_comb begin
    nxt_s = s_ff;
    two = s_ff.ctl[HC_TWO - 1];
    din = two ? sda_lvl : do_lvl;
    idle = (s_ff.st == H_IDLE);
    last = (s_ff.tmr == HALF_LAST);
    wfire = s_ff.aw_got & s_ff.w_got & ~s_ff.bvalid;
    map_ok = (s_ff.waddr[1:0] == 2'h0);
    nxt_s.tmr = last ? 3'h0 : s_ff.tmr + 3'h1; // [R12]
    if (~s_ff.aw_got & i_awvalid) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.waddr = i_awaddr;
    end
    if (~s_ff.w_got & i_wvalid) begin
      nxt_s.w_got = 1'b1;
      nxt_s.wdat = i_wdata[7:0];
      nxt_s.wlane = i_wstrb[0];
    end
    if (s_ff.bvalid & i_bready) begin
      nxt_s.bvalid = 1'b0;
    end
    case (s_ff.st)
      H_IDLE: begin
        nxt_s.tmr = 3'h0;
        nxt_s.ph = 1'b0;
        nxt_s.idx = 4'h0;
        if (!two) begin
          nxt_s.scl = 1'b0;
        end
        if (wfire & s_ff.wlane & map_ok) begin
          if (s_ff.waddr == OFF_TX) begin
            nxt_s.tx = s_ff.wdat;
          end else if (s_ff.waddr == OFF_CTRL) begin
            nxt_s.ctl = s_ff.wdat[5:1];
            if (s_ff.wdat[HC_GO]) begin
              nxt_s.st = (s_ff.wdat[HC_TWO] & s_ff.wdat[HC_START]) ?
                H_START : H_LOW;
            end
          end
        end
      end
      H_START: begin
        // Repeated-start safe: raise both lines, then drop SDA. [R04]
        nxt_s.sda = s_ff.ph ? 1'b0 : 1'b1;
        if (!s_ff.ph) begin
          nxt_s.scl = 1'b1;
          if (!scl_lvl) begin
            nxt_s.tmr = 3'h0; // [R03]
          end else if (last) begin
            nxt_s.ph = 1'b1;
          end
        end else if (last) begin
          nxt_s.st = H_LOW;
          nxt_s.scl = 1'b0;
          nxt_s.ph = 1'b0;
        end
      end
      H_LOW: begin
        nxt_s.scl = 1'b0;
        if (s_ff.idx == ACK_IDX) begin
          nxt_s.sda = s_ff.ctl[HC_READ - 1] ?
            s_ff.ctl[HC_NACK - 1] : 1'b1; // [R10]
        end else begin
          nxt_s.sda = (two & s_ff.ctl[HC_READ - 1]) ? 1'b1 : s_ff.tx[7];
        end
        if (last) begin
          nxt_s.st = H_HIGH;
          nxt_s.scl = 1'b1;
        end
      end
      H_HIGH: begin
        if (!scl_lvl) begin
          nxt_s.tmr = 3'h0; // [R03]
        end else if (last) begin
          nxt_s.scl = 1'b0;
          if (s_ff.idx == ACK_IDX) begin
            nxt_s.ack = din;
          end else begin
            nxt_s.rx = {s_ff.rx[6:0], din};
            nxt_s.tx = {s_ff.tx[6:0], 1'b0};
          end
          nxt_s.idx = s_ff.idx + 4'h1;
          nxt_s.st = H_LOW;
          if ((s_ff.idx == ACK_IDX) | (~two & (s_ff.idx == BIT_LAST))) begin
            nxt_s.st = (two & s_ff.ctl[HC_STOP - 1]) ? H_STOP : H_IDLE;
          end
        end
      end
      H_STOP: begin
        if (!s_ff.ph) begin
          nxt_s.scl = 1'b0;
          nxt_s.sda = 1'b0;
          if (last) begin
            nxt_s.ph = 1'b1;
            nxt_s.scl = 1'b1;
          end
        end else if (!scl_lvl) begin
          nxt_s.tmr = 3'h0; // [R03]
        end else if (last) begin
          nxt_s.sda = 1'b1;
          nxt_s.st = H_IDLE;
        end
      end
      default: nxt_s.st = H_IDLE;
    endcase
    if (wfire) begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = map_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_ff.rvalid & i_rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (~s_ff.rvalid & i_arvalid) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp = RESP_OKAY;
      case (i_araddr)
        OFF_CTRL: nxt_s.rdata = {2'h0, s_ff.ctl, 1'b0};
        OFF_TX: nxt_s.rdata = s_ff.tx;
        OFF_RX: nxt_s.rdata = s_ff.rx;
        OFF_STAT: nxt_s.rdata = {6'h00, s_ff.ack, ~idle};
        default: begin
          nxt_s.rdata = 8'h00;
          nxt_s.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      s_ff <= '{st: H_IDLE, tmr: 3'h0, idx: 4'h0, ph: 1'b0, scl: 1'b1,
        sda: 1'b1, tx: 8'h00, rx: 8'h00, ack: 1'b1, ctl: HCTRL_RST,
        aw_got: 1'b0, waddr: 4'h0, w_got: 1'b0, wdat: 8'h00, wlane: 1'b0,
        bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0, rdata: 8'h00,
        rresp: RESP_OKAY};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Two-wire lines are open drain; three-wire lines are driven.
  assign bus.h_scl_o = two ? 1'b0 : s_ff.scl;
  assign bus.h_scl_oen = two ? s_ff.scl : 1'b0;
  assign bus.h_sda_o = two ? 1'b0 : s_ff.sda;
  assign bus.h_sda_oen = two ? s_ff.sda : 1'b0;
  assign o_awready = ~s_ff.aw_got;
  assign o_wready = ~s_ff.w_got;
  assign o_bvalid = s_ff.bvalid;
  assign o_bresp = s_ff.bresp;
  assign o_arready = ~s_ff.rvalid;
  assign o_rvalid = s_ff.rvalid;
  assign o_rdata = {24'h000000, s_ff.rdata};
  assign o_rresp = s_ff.rresp;
endmodule
`default_nettype wire

/* testbench/usu_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module usu_sva (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic h_scl_oen,
  input wire logic d_scl_o,
  input wire logic d_scl_oen,
  input wire logic d_sda_oen,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);

  sequence start_cond;
    scl && $fell(sda);
  endsequence

  sequence start_then_fall;
    start_cond ##[1:40] $fell(scl);
  endsequence

  a_start_setup: assert property (
    start_cond |-> scl [*3]) else $error("start setup too short");
  a_start_hold: assert property (
    start_then_fall |-> ##[0:6] !d_scl_oen)
    else $error("clock not held after start");
  a_low_min: assert property (
    $fell(scl) |-> !scl [*2]) else $error("clock low phase too short");
  a_high_min: assert property (
    $rose(scl) |-> scl [*2]) else $error("clock high phase too short");
  a_wait_stretch: assert property (
    h_scl_oen && !scl |=> h_scl_oen)
    else $error("master drove clock before it rose");
  a_hold_from_low: assert property (
    $fell(d_scl_oen) |-> !$past(scl))
    else $error("slave pulled a high clock low");
  a_dev_open_drain: assert property (
    !d_scl_oen |-> !d_scl_o) else $error("slave drove clock high");
  a_dev_sda_low: assert property (
    scl && $past(scl) |-> !$fell(d_sda_oen))
    else $error("slave took data line while clock high");
endmodule
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
  checks_done++; \
  if ((a) !== (b)) begin \
    n_mismatch++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (b)); \
  end \
end
module tb;
  import usu_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic [1:0] cpu_addr = 2'h0;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] cpu_rdata;
  logic timer_match = 1'b0;
  logic data_dir = 1'b0;
  logic global_ie = 1'b1;
  logic start_irq;
  logic ovf_irq;
  logic awvalid = 1'b0;
  logic awready;
  logic [3:0] awaddr = 4'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [31:0] wdata = 32'h0;
  logic bvalid;
  logic bready = 1'b0;
  logic [1:0] bresp;
  logic arvalid = 1'b0;
  logic arready;
  logic [3:0] araddr = 4'h0;
  logic rvalid;
  logic rready = 1'b0;
  logic [31:0] rdata;
  logic [1:0] rresp;
  int n_mismatch = 0;
  int checks_done = 0;
  int seed = 70485;

  always #50 clock = ~clock;

  usu_if u_if();
  usu_unit i_usu_unit (.i_clock(clock), .i_resetn(resetn), .bus(u_if),
    .i_cpu_wr(cpu_wr), .i_cpu_rd(cpu_rd), .i_cpu_addr(cpu_addr),
    .i_cpu_wdata(cpu_wdata), .o_cpu_rdata(cpu_rdata),
    .i_timer_match(timer_match), .i_global_ie(global_ie),
    .i_data_dir(data_dir), .i_clk_dir(1'b0), .i_port_data(1'b1),
    .o_start_irq(start_irq), .o_ovf_irq(ovf_irq));
  usu_master i_usu_master (.i_clock(clock), .i_resetn(resetn), .bus(u_if),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
    .i_wstrb(4'hF), .o_bvalid(bvalid), .i_bready(bready),
    .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
    .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
    .o_rdata(rdata), .o_rresp(rresp));
  usu_sva i_usu_sva (.i_clock(clock), .i_resetn(resetn),
    .h_scl_oen(u_if.h_scl_oen), .d_scl_o(u_if.d_scl_o),
    .d_scl_oen(u_if.d_scl_oen), .d_sda_oen(u_if.d_sda_oen),
    .scl(u_if.scl), .sda(u_if.sda));

  task automatic print_verdict();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic timed_out();
    n_mismatch++;
    $display("[ERR] %0t wait limit reached", $time);
    print_verdict();
  endtask

  task automatic dev_wr(input logic [1:0] a, input logic [7:0] d,
      input logic tm);
    @(posedge clock);
    cpu_wr <= 1'b1;
    cpu_addr <= a;
    cpu_wdata <= d;
    timer_match <= tm;
    @(posedge clock);
    cpu_wr <= 1'b0;
    timer_match <= 1'b0;
  endtask

  task automatic dev_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clock);
    cpu_rd <= 1'b1;
    cpu_addr <= a;
    @(posedge clock);
    cpu_rd <= 1'b0;
    @(posedge clock);
    #1 d = cpu_rdata;
  endtask

  task automatic settle();
    @(posedge clock);
    #1;
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [7:0] d,
      output logic [1:0] r);
    int k;
    @(posedge clock);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {24'h0, d};
    bready <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (k == 200) timed_out();
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [7:0] d);
    int k;
    @(posedge clock);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (k == 200) timed_out();
    d = rdata[7:0];
    `CHK(rresp, RESP_OKAY)
    rready <= 1'b0;
  endtask

  function automatic logic sel_sig(int w);
    return (w == 0) ? start_irq : ((w == 1) ? ovf_irq : !u_if.d_scl_oen);
  endfunction

  task automatic wait_sig(input int w);
    int k;
    for (k = 0; k < 3000; k++) begin
      @(posedge clock);
      if (sel_sig(w) === 1'b1) break;
    end
    if (k == 3000) timed_out();
  endtask

  task automatic wait_busy();
    logic [7:0] s;
    int k;
    for (k = 0; k < 300; k++) begin
      axi_rd(OFF_STAT, s);
      if (s[HS_BUSY] === 1'b0) break;
    end
    if (k == 300) timed_out();
  endtask

  initial begin
    logic [7:0] v;
    logic [7:0] v2;
    logic [7:0] tx;
    logic [1:0] r;
    int n;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    axi_rd(OFF_CTRL, v);
    `CHK(v, 8'h02)
    dev_rd(DEV_CTRL, v);
    `CHK(v, CTRL_RST)
    axi_wr(4'h2, 8'h00, r);
    `CHK(r, RESP_SLVERR)
    // Software strobes with outputs off; the idle data line shifts in ones.
    repeat (4) begin
      v = 8'($random(seed));
      n = 1 + {$random(seed)} % 7;
      dev_wr(DEV_DATA, v, 1'b0);
      dev_wr(DEV_STAT, 8'hC0, 1'b0);
      repeat (n) dev_wr(DEV_CTRL, 8'h02, 1'b0);
      dev_rd(DEV_DATA, v2);
      `CHK(v2, 8'((v << n) | ((9'h001 << n) - 9'h001)))
      dev_rd(DEV_STAT, v2);
      `CHK(v2 & 8'hCF, {4'h8, 4'(n)})
    end
    dev_wr(DEV_STAT, 8'h0F, 1'b0);
    dev_wr(DEV_CTRL, 8'h42, 1'b0);
    settle();
    `CHK(ovf_irq, 1'b1)
    `CHK(start_irq, 1'b0)
    global_ie <= 1'b0;
    settle();
    `CHK(ovf_irq, 1'b0)
    global_ie <= 1'b1;
    dev_rd(DEV_STAT, v2);
    `CHK(v2 & 8'hCF, 8'hC0)
    dev_wr(DEV_STAT, 8'hC0, 1'b0);
    settle();
    `CHK(ovf_irq, 1'b0)
    dev_wr(DEV_CTRL, 8'h04, 1'b0);
    v = 8'($random(seed));
    dev_wr(DEV_DATA, v, 1'b0);
    dev_wr(DEV_CTRL, 8'h04, 1'b1);
    dev_rd(DEV_DATA, v2);
    `CHK(v2, {v[6:0], 1'b1})
    dev_wr(DEV_DATA, v, 1'b1);
    dev_rd(DEV_DATA, v2);
    `CHK(v2, v)
    // Two-wire write with start, slave acknowledges.
    dev_wr(DEV_STAT, 8'hF0, 1'b0);
    // Data out changes on the falling clock edge, as two-wire needs.
    dev_wr(DEV_CTRL, 8'hE8, 1'b0);
    dev_rd(DEV_CTRL, v);
    `CHK(v, 8'hE8)
    tx = 8'($random(seed));
    axi_wr(OFF_TX, tx, r);
    axi_wr(OFF_CTRL, 8'h07, r);
    wait_sig(0);
    wait_sig(2);
    repeat (4) @(posedge clock);
    dev_wr(DEV_STAT, 8'h80, 1'b0);
    wait_sig(1);
    dev_rd(DEV_DATA, v);
    `CHK(v, tx)
    dev_rd(DEV_STAT, v);
    `CHK(v & 8'hCF, 8'h40)
    dev_wr(DEV_DATA, 8'h00, 1'b0);
    @(posedge clock);
    data_dir <= 1'b1;
    dev_wr(DEV_STAT, 8'h4E, 1'b0);
    wait_busy();
    axi_rd(OFF_STAT, v);
    `CHK(v, 8'h00)
    // Master read of one byte ended without acknowledge.
    tx = 8'($random(seed));
    axi_wr(OFF_CTRL, 8'h33, r);
    // The latch keeps SDA steady while SCL is high; it opens on low.
    dev_wr(DEV_CTRL, 8'hE8, 1'b0);
    dev_wr(DEV_DATA, tx, 1'b0);
    dev_wr(DEV_STAT, 8'h40, 1'b0);
    wait_sig(1);
    @(posedge clock);
    data_dir <= 1'b0;
    dev_wr(DEV_STAT, 8'h4E, 1'b0);
    wait_busy();
    axi_rd(OFF_RX, v);
    `CHK(v, tx)
    axi_rd(OFF_STAT, v);
    `CHK(v, 8'h02)
    print_verdict();
  end
endmodule
`default_nettype wire
